// >>> hw/cfl_top.sv
// Fabric slice: routing, macrocells, pin control, test-port loader
`timescale 1ns/1ps
`default_nettype none
`include "cfl_regs.svh"
module cfl_top (
  // System
  input  wire logic            CLK_SYS,
  input  wire logic            RST,
  input  wire logic            CE,
  // Wishbone slave
  input  wire logic            WB_CYC_I,
  input  wire logic            WB_STB_I,
  input  wire logic            WB_WE_I,
  input  wire logic [7:0]      WB_ADR_I,
  input  wire logic [3:0]      WB_SEL_I,
  input  wire logic [31:0]     WB_DAT_I,
  output logic [31:0]          WB_DAT_O,
  output logic                 WB_ACK_O,
  // Fabric inputs
  input  wire logic [3:0]      DED_IN,
  input  wire logic            GLOBAL_CLR,
  input  wire logic            OUTPUT_ENABLE_PIN_A_N,
  input  wire logic            OUTPUT_ENABLE_PIN_B_N,
  // User pins
  input  wire cfl_pkg::cfl_pin_t IO_IN,
  output cfl_pkg::cfl_pin_t    IO_OUT,
  output cfl_pkg::cfl_pin_t    IO_OE,
  output cfl_pkg::cfl_pin_t    IO_PU,
  // Test port
  input  wire logic            TCK,
  input  wire logic            TMS,
  input  wire logic            TDI,
  output logic                 TDO
);
  import cfl_pkg::*;

  cfl_sys_t            st;
  cfl_sys_t            nx;
  cfl_lnk_t            ln;
  cfl_lnk_t            lx;
  logic [`CF_NPIN-1:0] pin_v;
  logic [`CF_NDED-1:0] ded_v;
  logic                gclr;
  logic [`CF_NMCT-1:0] d;
  logic [`CF_NMCT-1:0] mc_out;
  logic                pt;
  logic                raw;
  logic [`CF_SRCP-1:0] src;
  logic [`CF_NGOE-1:0] goe_v;
  logic                req_evt;
  logic                wb_hit;
  logic                busy;
  logic [`CF_AW-1:0]   ca;
  logic [`CF_DW-1:0]   cw;

  // Route address check
  function automatic logic rt_ok(input logic [`CF_AW-1:0] a);
    return a[`CF_A_RT] && (a[`CF_RI] < `CF_NIN);
  endfunction

  // Configuration readback
  function automatic logic [`CF_DW-1:0] rd_cfg(input cfl_sys_t s, input logic [`CF_AW-1:0] a);
    logic [`CF_DW-1:0] r;
    r = '0;
    if (rt_ok(a)) begin
      r[`CF_RB] = s.rte[a[`CF_RG]][a[`CF_RI]];
    end else if (!a[`CF_A_RT]) begin
      case (a[`CF_SP])
        `CF_SP_MSK: r = s.msk[a[`CF_MI]];
        `CF_SP_INV: r = s.inv[a[`CF_MI]];
        `CF_SP_MCC: r[`CF_MCCW-1:0] = s.mcc[a[`CF_MI]];
        `CF_SP_IOC: r[2:0] = s.ioc[a[`CF_MI]];
        `CF_SP_GOE: r[`CF_RB] = (a[`CF_GI] < `CF_NGOE) ? s.goe[a[`CF_GI]] : '0;
        `CF_SP_ISP: r[0] = s.isp;
        default: r = '0;
      endcase
    end
    return r;
  endfunction

  // Pin enable select
  function automatic logic oe_sel(input logic [2:0] sel, input logic [`CF_NGOE-1:0] g);
    logic [2:0] k;
    k = sel - `CF_OE_GOE0;
    case (sel)
      `CF_OE_LOW:  return 1'b0;
      `CF_OE_HIGH: return 1'b1;
      default:     return g[k];
    endcase
  endfunction

  // System domain next state
  always_comb begin
    nx = st;
    pt = 1'b0;
    raw = 1'b0;
    ca = ln.req[`CF_DR_A];
    cw = ln.req[`CF_DR_D];
    nx.s1 = {GLOBAL_CLR, OUTPUT_ENABLE_PIN_B_N, OUTPUT_ENABLE_PIN_A_N, DED_IN, IO_IN, ln.req_tgl};
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    for (int k = 0; k < `CF_SYNW; k++) begin
      if (st.s2[k] == st.s3[k]) begin
        nx.v[k] = st.s3[k];
      end
    end
    pin_v = st.v[`CF_SY_PIN +: `CF_NPIN];
    ded_v = st.v[`CF_SY_DED +: `CF_NDED];
    gclr = st.v[`CF_SY_GCLR];
    // Macrocells
    for (int m = 0; m < `CF_NMCT; m++) begin
      pt = &((st.rt[m / `CF_NMC] ^ st.inv[m]) | ~st.msk[m]); // R1 R5
      d[m] = st.mcc[m][`CF_MC_FAST] ? pin_v[m] : (pt ^ st.mcc[m][`CF_MC_POL]); // R2 R5
      raw = st.mcc[m][`CF_MC_REG] ? st.q[m] : d[m]; // R5
      mc_out[m] = (st.mcc[m][`CF_MC_SPEED] && !st.ctrl[`CF_CT_LP]) ? raw : st.slow[m]; // R16 R17
      nx.q[m] = (gclr && st.mcc[m][`CF_MC_GCLR]) ? 1'b0 : d[m]; // R2
      nx.slow[m] = raw; // R16
    end
    // Routing matrix: pin and macrocell feedback kept apart
    src = '0;
    src[`CF_NSRC-1:0] = {mc_out, pin_v, ded_v}; // R3 R10
    for (int g = 0; g < `CF_NGRP; g++) begin
      for (int i = 0; i < `CF_NIN; i++) begin
        nx.rt[g][i] = st.rte[g][i][`CF_RE] & src[st.rte[g][i][`CF_RS]]; // R3 R4
      end
    end
    // Global output enables
    goe_v = '0;
    if (!st.ctrl[`CF_CT_ENH]) begin
      goe_v[0] = !st.v[`CF_SY_OEA]; // R7
      goe_v[1] = !st.v[`CF_SY_OEB]; // R7
    end else begin
      for (int k = 0; k < `CF_NGOE; k++) begin
        case (st.goe[k][`CF_GSRC]) // R8
          `CF_GS_A:   goe_v[k] = !st.v[`CF_SY_OEA];
          `CF_GS_NA:  goe_v[k] = st.v[`CF_SY_OEA];
          `CF_GS_B:   goe_v[k] = !st.v[`CF_SY_OEB];
          `CF_GS_NB:  goe_v[k] = st.v[`CF_SY_OEB];
          `CF_GS_PIN: goe_v[k] = pin_v[st.goe[k][`CF_GIDX]];
          `CF_GS_MC:  goe_v[k] = mc_out[st.goe[k][`CF_GIDX]];
          default:    goe_v[k] = 1'b0;
        endcase
      end
    end
    // Pins
    for (int p = 0; p < `CF_NPIN; p++) begin
      nx.io_out[p] = mc_out[p];
      nx.io_oe[p] = !st.isp && oe_sel(st.ioc[p], goe_v); // R6 R9 R12
    end
    nx.io_pu = {`CF_NPIN{st.isp}}; // R12
    // Configuration request from the test port
    req_evt = (st.s2[`CF_SY_REQ] == st.s3[`CF_SY_REQ]) && (st.s3[`CF_SY_REQ] != st.v[`CF_SY_REQ]);
    if (req_evt) begin
      if (ln.req[`CF_DR_OP]) begin
        if (rt_ok(ca)) begin
          nx.rte[ca[`CF_RG]][ca[`CF_RI]] = cw[`CF_RB]; // R11
        end else if (!ca[`CF_A_RT]) begin
          case (ca[`CF_SP]) // R11
            `CF_SP_MSK: nx.msk[ca[`CF_MI]] = cw;
            `CF_SP_INV: nx.inv[ca[`CF_MI]] = cw;
            `CF_SP_MCC: nx.mcc[ca[`CF_MI]] = cw[`CF_MCCW-1:0];
            `CF_SP_IOC: nx.ioc[ca[`CF_MI]] = cw[2:0];
            `CF_SP_GOE: begin
              if (ca[`CF_GI] < `CF_NGOE) begin
                nx.goe[ca[`CF_GI]] = cw[`CF_RB];
              end
            end
            `CF_SP_ISP: nx.isp = cw[0];
            default: ;
          endcase
        end
        nx.wcnt = st.wcnt + `CF_ONE8;
      end else begin
        nx.rd = rd_cfg(st, ca); // R11
      end
      nx.ack_tgl = ~st.ack_tgl;
    end
    // Wishbone registers
    wb_hit = WB_CYC_I && WB_STB_I && !st.wb_ack;
    nx.wb_ack = wb_hit;
    if (wb_hit) begin
      nx.wb_dat = '0;
      case (WB_ADR_I)
        `CF_WB_CTRL: begin
          nx.wb_dat[1:0] = st.ctrl;
          if (WB_WE_I && WB_SEL_I[0]) begin
            nx.ctrl = WB_DAT_I[1:0]; // R17
          end
        end
        `CF_WB_STAT: begin
          nx.wb_dat[`CF_ST_ISP] = st.isp;
          nx.wb_dat[`CF_ST_CNT] = st.wcnt;
        end
        `CF_WB_PINS: nx.wb_dat = st.io_out;
        `CF_WB_MCO:  nx.wb_dat = mc_out;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st <= '0;
    end else if (CE) begin
      st <= nx;
    end
  end

  // Test port domain next state
  always_comb begin
    lx = ln;
    busy = ln.req_tgl != ln.av;
    lx.a1 = st.ack_tgl;
    lx.a2 = ln.a1;
    lx.a3 = ln.a2;
    if (ln.a2 == ln.a3) begin
      lx.av = ln.a3;
    end
    case (ln.state)
      LK_IDLE: begin
        if (TMS) begin
          lx.sr = '0;
          lx.sr[`CF_DR_D] = st.rd; // R11
          lx.sr[`CF_DR_OP] = busy;
          lx.state = LK_SHIFT;
        end
      end
      LK_SHIFT: begin
        if (TMS) begin
          lx.sr = {TDI, ln.sr[`CF_SRW-1:1]}; // R11
        end else begin
          lx.req = ln.sr; // R11
          lx.req_tgl = ~ln.req_tgl;
          lx.state = LK_IDLE;
        end
      end
      default: lx.state = LK_IDLE;
    endcase
    lx.tdo = lx.sr[0];
    if (ln.rs2 && ln.rs3) begin
      lx = '0;
      lx.rs2 = ln.rs1;
      lx.rs3 = ln.rs2;
    end
    lx.rs1 = RST;
    lx.rs2 = ln.rs1;
    lx.rs3 = ln.rs2;
  end

  always_ff @(posedge TCK) begin
    ln <= lx;
  end

  assign WB_DAT_O = st.wb_dat;
  assign WB_ACK_O = st.wb_ack;
  assign IO_OUT   = st.io_out;
  assign IO_OE    = st.io_oe;
  assign IO_PU    = st.io_pu;
  assign TDO      = ln.tdo;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  sequence wb_req_s;
    CE && WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence wb_ans_s;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  sequence cfg_wr_s;
    CE && req_evt && ln.req[`CF_DR_OP];
  endsequence

  isp_float_a: assert property ((CE && st.isp) |=> (IO_OE == '0 && IO_PU == '1)) // R12
    else $error("pin driven during programming");
  tie_low_a: assert property ((CE && st.ioc[0] == `CF_OE_LOW) |=> !IO_OE[0]) // R9
    else $error("tied-low pin driven");
  tie_high_a: assert property ((CE && !st.isp && st.ioc[0] == `CF_OE_HIGH) |=> IO_OE[0]) // R9
    else $error("tied-high pin not driven");
  route_gate_a: assert property ((CE && !st.rte[0][0][`CF_RE]) |=> !st.rt[0][0]) // R3
    else $error("unselected route not gated");
  no_skew_a: assert property ($past(CE && st.rte[0][0] == st.rte[1][0]) |-> st.rt[0][0] == st.rt[1][0]) // R4
    else $error("routed copies skewed");
  dev_lowpow_a: assert property (st.ctrl[`CF_CT_LP] |-> (mc_out == st.slow)) // R17
    else $error("device low power ignored");
  comb_fast_a: assert property ((!st.ctrl[`CF_CT_LP] && st.mcc[0][`CF_MC_SPEED] && !st.mcc[0][`CF_MC_REG])
                                |-> mc_out[0] == d[0]) // R5
    else $error("combinational macrocell delayed");
  basic_oe_a: assert property ((CE && !st.ctrl[`CF_CT_ENH] && !st.isp && st.ioc[2] == `CF_OE_GOE0)
                               |=> IO_OE[2] == !$past(st.v[`CF_SY_OEA])) // R7
    else $error("basic enable not from pin");
  cfg_write_a: assert property (cfg_wr_s |=> st.wcnt == $past(st.wcnt) + `CF_ONE8) // R11
    else $error("config write not counted");
  wb_ack_a: assert property (wb_req_s |=> wb_ans_s)
    else $error("bus answer not one cycle");
endmodule // cfl_top
`default_nettype wire

// >>> inc/cfl_regs.svh
// Constants for the programmable fabric slice
//Function
//R1 - Each logic block group has 16 macrocells and 36 routed inputs.
//R2 - Groups also get a global clear and fast pin-to-register paths.
//R3 - Routing matrix takes all inputs, pins, macrocells; each pick gated by a cell.
//R4 - Every routed signal sees the same one-stage delay, so no skew.
//R5 - Macrocell is registered or combinational: product term, select, register.
//R6 - Each pin is input, output or both; enable from a global signal or tie.
//R7 - Basic variant: two global enables from two active-low enable pins.
//R8 - Enhanced variant: six global enables from enable pins, pins or macrocells.
//R9 - Tie low keeps the pin undriven; tie high keeps it driven.
//R10 - Pin feedback and macrocell feedback are separate; input pins free the macrocell.
//R11 - Configuration is written and read back over the 4-pin test port.
//R12 - During programming every user pin floats with a weak pull-up.
//R13 - Programmer uses an adaptive or a constant programming algorithm.
//R14 - Programmer allows 4.50 s plus 504,000 test clocks to program.
//R15 - Programmer allows 0.03 s plus 308,000 test clocks to verify.
//R16 - Per-macrocell speed bit; off adds a low-power delay stage.
//R17 - Low power applies to chosen macrocells or the whole device.
//R18 - Programmer estimates time as pulse time plus cycles over clock rate.
`ifndef CFL_REGS_SVH
`define CFL_REGS_SVH
`define CF_NGRP 2
`define CF_NMC 16
`define CF_NMCT 32
`define CF_NIN 36
`define CF_NPIN 32
`define CF_NDED 4
`define CF_NSRC 68
`define CF_SRCP 128
`define CF_NGOE 6
`define CF_MCCW 5
`define CF_DW 36
`define CF_AW 9
`define CF_SRW 46
`define CF_SYNW 40
`define CF_SY_REQ 0
`define CF_SY_PIN 1
`define CF_SY_DED 33
`define CF_SY_OEA 37
`define CF_SY_OEB 38
`define CF_SY_GCLR 39
`define CF_MC_REG 0
`define CF_MC_POL 1
`define CF_MC_SPEED 2
`define CF_MC_FAST 3
`define CF_MC_GCLR 4
`define CF_OE_LOW 3'h0
`define CF_OE_HIGH 3'h1
`define CF_OE_GOE0 3'h2
`define CF_GS_A 3'h0
`define CF_GS_NA 3'h1
`define CF_GS_B 3'h2
`define CF_GS_NB 3'h3
`define CF_GS_PIN 3'h4
`define CF_GS_MC 3'h5
`define CF_A_RT 8
`define CF_RG 6
`define CF_RI 5:0
`define CF_SP 7:5
`define CF_MI 4:0
`define CF_GI 2:0
`define CF_SP_MSK 3'h0
`define CF_SP_INV 3'h1
`define CF_SP_MCC 3'h2
`define CF_SP_IOC 3'h3
`define CF_SP_GOE 3'h4
`define CF_SP_ISP 3'h5
`define CF_RE 7
`define CF_RS 6:0
`define CF_RB 7:0
`define CF_GSRC 2:0
`define CF_GIDX 7:3
`define CF_DR_OP 45
`define CF_DR_A 44:36
`define CF_DR_D 35:0
`define CF_WB_CTRL 8'h00
`define CF_WB_STAT 8'h04
`define CF_WB_PINS 8'h08
`define CF_WB_MCO 8'h0c
`define CF_CT_LP 0
`define CF_CT_ENH 1
`define CF_ST_ISP 0
`define CF_ST_CNT 15:8
`define CF_ONE8 8'h01
`endif

// >>> inc/cfl_pkg.sv
// Types for the programmable fabric slice
`default_nettype none
package cfl_pkg;
`include "cfl_regs.svh"
typedef logic [`CF_NPIN-1:0] cfl_pin_t;
typedef enum logic {LK_IDLE, LK_SHIFT} cfl_lst_t;
typedef struct packed {
  logic [`CF_SYNW-1:0]                           s1;
  logic [`CF_SYNW-1:0]                           s2;
  logic [`CF_SYNW-1:0]                           s3;
  logic [`CF_SYNW-1:0]                           v;
  logic [`CF_NMCT-1:0][`CF_NIN-1:0]              msk;
  logic [`CF_NMCT-1:0][`CF_NIN-1:0]              inv;
  logic [`CF_NMCT-1:0][`CF_MCCW-1:0]             mcc;
  logic [`CF_NPIN-1:0][2:0]                      ioc;
  logic [`CF_NGOE-1:0][7:0]                      goe;
  logic [`CF_NGRP-1:0][`CF_NIN-1:0][7:0]         rte;
  logic [`CF_NGRP-1:0][`CF_NIN-1:0]              rt;
  logic [`CF_NMCT-1:0]                           q;
  logic [`CF_NMCT-1:0]                           slow;
  logic [`CF_NPIN-1:0]                           io_out;
  logic [`CF_NPIN-1:0]                           io_oe;
  logic [`CF_NPIN-1:0]                           io_pu;
  logic                                          isp;
  logic [1:0]                                    ctrl;
  logic [7:0]                                    wcnt;
  logic [`CF_DW-1:0]                             rd;
  logic                                          ack_tgl;
  logic                                          wb_ack;
  logic [31:0]                                   wb_dat;
} cfl_sys_t;
typedef struct packed {
  logic                rs1;
  logic                rs2;
  logic                rs3;
  logic                a1;
  logic                a2;
  logic                a3;
  logic                av;
  cfl_lst_t            state;
  logic [`CF_SRW-1:0]  sr;
  logic [`CF_SRW-1:0]  req;
  logic                req_tgl;
  logic                tdo;
} cfl_lnk_t;
endpackage
`default_nettype wire

// >>> verif/cfl_prog_model.sv
// Test-port programmer model sending configuration frames
`timescale 1ns/1ps
`default_nettype none
`include "cfl_regs.svh"
module cfl_prog_model (
  // Test port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // Worst-case budget for a full part; this bench loads only a few words
  localparam int PROG_CYC = 504000;
  localparam int VER_CYC = 308000;
  // Total time: pulse time plus cycles over test clock rate
  function automatic real est_s(input real pulse_s, input int ncyc, input real tck_hz);
    return pulse_s + ncyc / tck_hz;
  endfunction
  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
  end
  // One test clock of 12 ns; lines change after the falling edge
  task automatic tick(input logic m, input logic d);
    tms = m;
    tdi = d;
    #6 tck = 1'b1;
    #6 tck = 1'b0;
  endtask
  // Clocks with mode low; data line shows no stale value
  task automatic idle(input int n);
    repeat (n) tick(1'b0, ~tdi);
  endtask
  // Capture, 46 shifts LSB first, update, fixed settle step
  task automatic xfer(input logic [`CF_SRW-1:0] w, output logic [`CF_SRW-1:0] cap);
    tick(1'b1, ~w[0]);
    cap[0] = tdo;
    for (int i = 0; i < `CF_SRW; i++) begin
      tick(1'b1, w[i]);
      if (i < `CF_SRW-1) cap[i+1] = tdo;
    end
    tick(1'b0, ~w[`CF_SRW-1]);
    idle(16);
  endtask
endmodule // cfl_prog_model
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the fabric slice
`timescale 1ns/1ps
`default_nettype none
`include "cfl_regs.svh"
module tb_top;
  import cfl_pkg::*;
  logic               clk_sys, rst, cyc, stb, we, ack, oe_a_n, oe_b_n, tck, tms, tdi, tdo;
  logic [7:0]         adr;
  logic [31:0]        wdat, rdat, q;
  logic [3:0]         ded;
  cfl_pin_t           pin_in, pin_out, pin_oe, pin_pu, ext;
  logic [`CF_SRW-1:0] cap;
  int                 num_errors, n_checks, cyc_cnt, nwr;
  // Pin level from device drive, pull-up or outside driver
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pin_pu) | (~pin_oe & ~pin_pu & ext);
  cfl_top cfl_top_inst (.CLK_SYS(clk_sys), .RST(rst), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .DED_IN(ded), .GLOBAL_CLR(1'b0), .OUTPUT_ENABLE_PIN_A_N(oe_a_n), .OUTPUT_ENABLE_PIN_B_N(oe_b_n),
    .IO_IN(pin_in), .IO_OUT(pin_out), .IO_OE(pin_oe), .IO_PU(pin_pu), .TCK(tck), .TMS(tms),
    .TDI(tdi), .TDO(tdo));
  cfl_prog_model cfl_prog_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [45:0] got, input logic [45:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ws(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Classic single cycle, entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 100);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic cfg(input logic [8:0] a, input logic [35:0] d);
    cfl_prog_model_inst.xfer({1'b1, a, d}, cap);
    nwr++;
    ws(2);
  endtask
  // Enable expected for a pin control code in the basic variant
  function automatic logic exp_oe(input logic [2:0] c, input logic a_n, input logic b_n);
    return (c == 3'h1) | ((c == 3'h2) & ~a_n) | ((c == 3'h3) & ~b_n);
  endfunction
  initial begin
    rst = 1'b1;
    {cyc, stb, we, adr, wdat, ded, ext} = '0;
    {oe_a_n, oe_b_n} = 2'b11;
    {num_errors, n_checks, cyc_cnt, nwr} = '0;
    void'($urandom(32'h33ed));
    fork
      cfl_prog_model_inst.idle(8);
    join_none
    ws(5);
    rst <= 1'b0;
    ws(20);
    chk(pin_oe, 32'h0);
    chk(pin_pu, 32'h0);
    cfg(9'h100, 36'h80);
    cfg(9'h000, 36'h1);
    cfg(9'h060, 36'h1);
    for (int v = 0; v < 4; v++) begin
      cfg(9'h040, {32'h0, v[1], v[0], 1'b0});
      repeat (3) begin
        ded <= 4'($urandom);
        ws(14);
        chk(pin_out[0], ded[0] ^ v[0]);
        chk(pin_oe[0], 1'b1);
      end
    end
    cfg(9'h101, 36'h85);
    cfg(9'h000, 36'h2);
    cfg(9'h040, 36'h4);
    repeat (4) begin
      ext <= $urandom;
      ws(14);
      chk(pin_out[0], ext[1]);
      chk(pin_oe[1], 1'b0);
      wb(1'b0, `CF_WB_PINS, 32'h0, q);
      chk(q[0], ext[1]);
    end
    cfg(9'h062, 36'h2);
    cfg(9'h063, 36'h3);
    for (int k = 0; k < 4; k++) begin
      {oe_a_n, oe_b_n} <= 2'(k);
      ws(10);
      chk(pin_oe[2], exp_oe(3'h2, k[1], k[0]));
      chk(pin_oe[3], exp_oe(3'h3, k[1], k[0]));
    end
    wb(1'b1, `CF_WB_CTRL, 32'h2, q);
    cfg(9'h066, 36'h4);
    for (int s = 0; s < 2; s++) begin
      cfg(9'h082, s ? {5'd0, 3'h5} : {5'd5, 3'h4});
      repeat (3) begin
        ext <= $urandom;
        ws(14);
        chk(pin_oe[6], s ? ext[1] : ext[5]);
      end
    end
    cfg(9'h0a0, 36'h1);
    ws(4);
    chk(pin_oe, 32'h0);
    chk(pin_pu, 32'hffffffff);
    wb(1'b0, `CF_WB_STAT, 32'h0, q);
    chk(q, {16'h0, 8'(nwr), 8'h1});
    cfg(9'h0a0, 36'h0);
    ws(4);
    chk(pin_pu, 32'h0);
    chk(pin_oe[0], 1'b1);
    cfl_prog_model_inst.xfer({1'b0, 9'h000, 36'h0}, cap);
    cfl_prog_model_inst.xfer({1'b0, 9'h000, 36'h0}, cap);
    chk(cap, 46'h2);
    wb(1'b1, 8'h10, 32'hffffffff, q);
    wb(1'b0, 8'h10, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b1, `CF_WB_CTRL, 32'h3, q);
    wb(1'b0, `CF_WB_CTRL, 32'h0, q);
    chk(q, 32'h3);
    ext <= ~ext;
    ws(16);
    chk(pin_out[0], ext[1]);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
